// ===== pudc_pkg.sv
// Purpose: shared constants for the presettable up/down counter block
// Assumes: 32-bit APB, word-aligned registers
// Notes: offsets are byte addresses
package pudc_pkg;

    // ==========================================================
    // widths
    localparam int PUDC_CNT_W = 4;
    localparam int PUDC_ADDR_W = 12;
    localparam int PUDC_DATA_W = 32;
    localparam int PUDC_WRAP_W = 16;

    // ==========================================================
    // register offsets
    localparam logic [PUDC_ADDR_W-1:0] PUDC_OFS_CTRL = 12'h000;
    localparam logic [PUDC_ADDR_W-1:0] PUDC_OFS_STATUS = 12'h004;
    localparam logic [PUDC_ADDR_W-1:0] PUDC_OFS_PRESET = 12'h008;
    localparam logic [PUDC_ADDR_W-1:0] PUDC_OFS_WRAPS = 12'h00c;

    // ==========================================================
    // ctrl fields
    localparam int PUDC_CTRL_INHIBIT_BIT = 0;
    localparam int PUDC_CTRL_SWLOAD_BIT = 1;

    // ==========================================================
    // status fields
    localparam int PUDC_ST_CNT_LSB = 0;
    localparam int PUDC_ST_TC_BIT = 4;
    localparam int PUDC_ST_DOWN_BIT = 5;
    localparam int PUDC_ST_LOAD_BIT = 6;
    localparam int PUDC_ST_RC_BIT = 7;
    localparam int PUDC_ST_INH_BIT = 8;

    // ==========================================================
    // reset values, the wrap increment and the direction type
    localparam logic [PUDC_CNT_W-1:0] PUDC_CNT_RST = 4'h0;
    localparam logic [PUDC_DATA_W-1:0] PUDC_RDATA_ZERO = 32'h0000_0000;
    localparam logic [PUDC_WRAP_W-1:0] PUDC_WRAP_RST = 16'h0000;
    localparam logic [PUDC_WRAP_W-1:0] PUDC_WRAP_ONE = 16'h0001;

    typedef enum logic {PUDC_DIR_UP, PUDC_DIR_DOWN} pudc_dir_t;

endpackage

// ===== pudc_stage_if.sv
// Purpose: carrier between the counter top and its count stage
// Assumes: single clock domain
// Notes: step is a one-cycle pulse
`timescale 1ns/1ps
interface pudc_stage_if #(parameter int WIDTH = 4);
    logic load_n;
    logic [WIDTH-1:0] load_data;
    logic step;
    logic count_down;
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] count_nxt;
    logic term;
    logic term_nxt;
    logic carry;

    modport ctrl (
        output load_n,
        output load_data,
        output step,
        output count_down,
        input count,
        input count_nxt,
        input term,
        input term_nxt,
        input carry
    );

    modport stage (
        input load_n,
        input load_data,
        input step,
        input count_down,
        output count,
        output count_nxt,
        output term,
        output term_nxt,
        output carry
    );
endinterface

// ===== pudc_stage.sv
// Purpose: modulo 2^WIDTH up/down count stage with level preset
// Assumes: step already qualified by enable and clock edge
// Notes: terminal flag is registered from the next count
`timescale 1ns/1ps
module pudc_stage
    import pudc_pkg::*;
#(
    parameter int WIDTH = PUDC_CNT_W
)
(
    input wire logic pclk,
    input wire logic presetn,
    pudc_stage_if.stage sif
);
    localparam logic [WIDTH-1:0] ONE = WIDTH'(1);
    localparam logic [WIDTH-1:0] ALL_ONES = {WIDTH{1'b1}};
    localparam logic [WIDTH-1:0] ZERO = '0;

    logic [WIDTH-1:0] count_r;
    logic term_r;
    logic [WIDTH-1:0] count_nxt;
    logic term_nxt;

    // ==========================================================
    // next count
    always_comb
    begin
        count_nxt = count_r;
        if (!sif.load_n)
        begin
            count_nxt = sif.load_data;
        end
        else if (sif.step)
        begin
            if (sif.count_down)
            begin
                count_nxt = count_r - ONE;
            end
            else
            begin
                count_nxt = count_r + ONE;
            end
        end
    end

    // direction enters here directly, so a change of direction
    // moves the flag even when the count stands still
    always_comb
    begin
        if (sif.count_down)
        begin
            term_nxt = (count_nxt == ZERO);
        end
        else
        begin
            term_nxt = (count_nxt == ALL_ONES);
        end
    end

    // ==========================================================
    // storage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_r <= PUDC_CNT_RST;
        end
        else
        begin
            count_r <= count_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            term_r <= 1'b0;
        end
        else
        begin
            term_r <= term_nxt;
        end
    end

    assign sif.count = count_r;
    assign sif.count_nxt = count_nxt;
    assign sif.term = term_r;
    assign sif.term_nxt = term_nxt;
    assign sif.carry = sif.load_n & sif.step & term_r;
endmodule

// ===== pudc_counter.sv
// Purpose: presettable 4-bit up/down counter with APB status and control
// Assumes: all pins synchronous to pclk; count_clock sampled, not a clock
// Notes: pin effects appear one pclk after the pin changes
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module pudc_counter
    import pudc_pkg::*;
#(
    parameter int WIDTH = PUDC_CNT_W
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PUDC_ADDR_W-1:0] paddr,
    input wire logic [PUDC_DATA_W-1:0] pwdata,
    output logic [PUDC_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic count_clock,
    input wire logic count_enable_n,
    input wire logic count_down,
    input wire logic preset_load_n,
    input wire logic [WIDTH-1:0] preset_data_in,
    output logic [WIDTH-1:0] count_value_out,
    output logic terminal_count_flag,
    output logic ripple_clock_out
);
    import pudc_pkg::*;

    // ==========================================================
    // declarations
    pudc_stage_if #(.WIDTH(WIDTH)) sif ();

    logic clk_prev_r;
    logic clk_rise;
    logic inhibit_r;
    logic swload_r;
    logic [WIDTH-1:0] preset_r;
    logic [PUDC_WRAP_W-1:0] wraps_r;
    logic [PUDC_WRAP_W-1:0] wraps_nxt;
    logic [WIDTH-1:0] count_out_r;
    logic term_out_r;
    logic ripple_r;
    logic ripple_nxt;
    logic enable_eff;
    logic load_eff_n;
    logic [WIDTH-1:0] load_data;
    logic [PUDC_DATA_W-1:0] prdata_r;
    logic [PUDC_DATA_W-1:0] rdata_nxt;
    logic pready_r;
    logic pslverr_r;
    logic addr_hit;
    logic setup_ph;
    logic access_wr;
    logic [PUDC_DATA_W-1:0] status_word;

    // ==========================================================
    // count clock edge detection
    // the pin is treated as a sampled level, so the highest usable
    // count rate is half of pclk
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clk_prev_r <= 1'b1;
        end
        else
        begin
            clk_prev_r <= count_clock;
        end
    end

    assign clk_rise = count_clock & ~clk_prev_r;

    // ==========================================================
    // enable and load qualification
    // software inhibit acts like a high enable pin, which keeps the
    // stop-the-chain behaviour of the ripple output intact
    assign enable_eff = ~count_enable_n & ~inhibit_r;

    // pin load wins over the software load request
    assign load_eff_n = preset_load_n & ~swload_r;
    assign load_data = !preset_load_n ? preset_data_in : preset_r;

    assign sif.load_n = load_eff_n;
    assign sif.load_data = load_data;
    assign sif.step = clk_rise & enable_eff;
    assign sif.count_down = count_down;

    pudc_stage #(.WIDTH(WIDTH)) u_stage (
        .pclk(pclk),
        .presetn(presetn),
        .sif(sif)
    );

    // ==========================================================
    // pin outputs, all registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_out_r <= PUDC_CNT_RST;
        end
        else
        begin
            count_out_r <= sif.count_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            term_out_r <= 1'b0;
        end
        else
        begin
            term_out_r <= sif.term_nxt;
        end
    end

    // low only while armed, enabled and the count clock is low;
    // built from the next flag and registered so it cannot spike on decode
    always_comb
    begin
        ripple_nxt = 1'b1;
        if (sif.term_nxt && enable_eff && !count_clock)
        begin
            ripple_nxt = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ripple_r <= 1'b1;
        end
        else
        begin
            ripple_r <= ripple_nxt;
        end
    end

    assign count_value_out = count_out_r;
    assign terminal_count_flag = term_out_r;
    assign ripple_clock_out = ripple_r;

    // ==========================================================
    // apb decode
    assign setup_ph = psel & ~penable;
    assign access_wr = psel & penable & pwrite & pready_r;
    assign addr_hit = (paddr == PUDC_OFS_CTRL) || (paddr == PUDC_OFS_STATUS) ||
                      (paddr == PUDC_OFS_PRESET) || (paddr == PUDC_OFS_WRAPS);

    always_comb
    begin
        status_word = PUDC_RDATA_ZERO;
        status_word[PUDC_ST_CNT_LSB +: WIDTH] = sif.count;
        status_word[PUDC_ST_TC_BIT] = sif.term;
        status_word[PUDC_ST_DOWN_BIT] = count_down;
        status_word[PUDC_ST_LOAD_BIT] = ~preset_load_n;
        status_word[PUDC_ST_RC_BIT] = ripple_r;
        status_word[PUDC_ST_INH_BIT] = inhibit_r;
    end

    always_comb
    begin
        rdata_nxt = PUDC_RDATA_ZERO;
        unique case (paddr)
            PUDC_OFS_CTRL:
            begin
                rdata_nxt[PUDC_CTRL_INHIBIT_BIT] = inhibit_r;
            end
            PUDC_OFS_STATUS:
            begin
                rdata_nxt = status_word;
            end
            PUDC_OFS_PRESET:
            begin
                rdata_nxt[WIDTH-1:0] = preset_r;
            end
            PUDC_OFS_WRAPS:
            begin
                rdata_nxt[PUDC_WRAP_W-1:0] = wraps_r;
            end
            default:
            begin
                rdata_nxt = PUDC_RDATA_ZERO;
            end
        endcase
    end

    // ==========================================================
    // apb answer: ready is registered from the setup cycle, so every
    // access completes at its first access edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r <= 1'b0;
        end
        else
        begin
            pready_r <= setup_ph;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pslverr_r <= 1'b0;
        end
        else
        begin
            pslverr_r <= setup_ph & ~addr_hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= PUDC_RDATA_ZERO;
        end
        else if (setup_ph && !pwrite)
        begin
            prdata_r <= rdata_nxt;
        end
        else if (!psel)
        begin
            prdata_r <= PUDC_RDATA_ZERO;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // ==========================================================
    // control register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            inhibit_r <= 1'b0;
        end
        else if (access_wr && paddr == PUDC_OFS_CTRL)
        begin
            inhibit_r <= pwdata[PUDC_CTRL_INHIBIT_BIT];
        end
    end

    // self-clearing, one pclk of load
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            swload_r <= 1'b0;
        end
        else
        begin
            swload_r <= access_wr && (paddr == PUDC_OFS_CTRL) &&
                        pwdata[PUDC_CTRL_SWLOAD_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            preset_r <= PUDC_CNT_RST;
        end
        else if (access_wr && paddr == PUDC_OFS_PRESET)
        begin
            preset_r <= pwdata[WIDTH-1:0];
        end
    end

    // ==========================================================
    // wrap counter: a carry in the same cycle as a clear survives
    always_comb
    begin
        wraps_nxt = wraps_r;
        if (access_wr && paddr == PUDC_OFS_WRAPS)
        begin
            wraps_nxt = sif.carry ? PUDC_WRAP_ONE : PUDC_WRAP_RST;
        end
        else if (sif.carry)
        begin
            wraps_nxt = wraps_r + PUDC_WRAP_ONE;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wraps_r <= PUDC_WRAP_RST;
        end
        else
        begin
            wraps_r <= wraps_nxt;
        end
    end
endmodule

// ===== pudc_counter_sva.sv
// Purpose: port checker for the up/down counter
// Assumes: bound to pudc_counter
// Notes: pin effects land one pclk late
`timescale 1ns/1ps
module pudc_counter_sva
    import pudc_pkg::*;
#(
    parameter int WIDTH = PUDC_CNT_W
)
(
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [pudc_pkg::PUDC_ADDR_W-1:0] paddr,
    input logic [pudc_pkg::PUDC_DATA_W-1:0] pwdata,
    input logic [pudc_pkg::PUDC_DATA_W-1:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic count_clock,
    input logic count_enable_n,
    input logic count_down,
    input logic preset_load_n,
    input logic [WIDTH-1:0] preset_data_in,
    input logic [WIDTH-1:0] count_value_out,
    input logic terminal_count_flag,
    input logic ripple_clock_out
);
    // ==========================================================
    // helpers
    logic clk_q;
    logic sel_q;
    logic inh_r;
    logic rise;
    logic quiet;
    assign rise = count_clock && !clk_q;
    // bus traffic may load or inhibit, so counting checks skip it
    assign quiet = preset_load_n && !psel && !sel_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clk_q <= 1'h1;
            sel_q <= 1'h0;
            inh_r <= 1'h0;
        end
        else
        begin
            clk_q <= count_clock;
            sel_q <= psel;
            if (psel && penable && pready && pwrite && paddr == PUDC_OFS_CTRL)
            begin
                inh_r <= pwdata[PUDC_CTRL_INHIBIT_BIT];
            end
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================================
    // assertions
    load_a: assert property (!preset_load_n |=> count_value_out == $past(preset_data_in))
        else $error("count did not take preset data");
    hold_a: assert property (quiet && (count_enable_n || inh_r || !rise) |=>
        $stable(count_value_out)) else $error("count moved without a step");
    up_a: assert property (quiet && !inh_r && !count_enable_n && rise && !count_down |=>
        count_value_out == $past(count_value_out) + 1'h1) else $error("bad up step");
    down_a: assert property (quiet && !inh_r && !count_enable_n && rise && count_down |=>
        count_value_out == $past(count_value_out) - 1'h1) else $error("bad down step");
    flag_a: assert property ($past(presetn) && $stable(count_down) |->
        terminal_count_flag == (count_down ? count_value_out == '0 : &count_value_out))
        else $error("terminal flag wrong");
    rip_low_a: assert property (!ripple_clock_out |-> terminal_count_flag &&
        !$past(count_enable_n) && !$past(count_clock)) else $error("stray ripple pulse");
    rip_arm_a: assert property ($past(presetn) && terminal_count_flag && !inh_r &&
        !$past(count_enable_n) && !$past(count_clock) && !$past(psel) |-> !ripple_clock_out)
        else $error("ripple pulse missing");
    ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready in access cycle");
    err_a: assert property (psel && penable && paddr > PUDC_OFS_WRAPS |-> pslverr)
        else $error("unmapped access not refused");
endmodule

bind pudc_counter pudc_counter_sva #(.WIDTH(WIDTH)) i_pudc_counter_sva (.*);

// ===== pudc_ctl_model.sv
// Purpose: controlling logic driving the counter pins
// Assumes: run held for whole clock periods
// Notes: count clock is 2 low, 2 high pclk and idles high
`timescale 1ns/1ps
module pudc_ctl_model
(
    input logic pclk,
    input logic presetn,
    input logic run,
    input logic en_req,
    input logic dir_req,
    output logic count_clock,
    output logic count_enable_n,
    output logic count_down
);
    // ==========================================================
    // clock and control pins
    logic [1:0] ph_r;
    logic safe;
    // changes only where the clock stays high across the edge
    assign safe = count_clock && (!run || ph_r == 2'h0);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ph_r <= 2'h0;
            count_clock <= 1'h1;
            count_enable_n <= 1'h1;
            count_down <= 1'h0;
        end
        else
        begin
            ph_r <= run ? ph_r + 2'h1 : 2'h0;
            // two low pclk outlast the one-pclk ripple lag of a stage
            count_clock <= !(run && ph_r[0] != ph_r[1]);
            if (en_req)
            begin
                count_enable_n <= 1'h0;
            end
            else if (safe)
            begin
                count_enable_n <= 1'h1;
            end
            if (safe)
            begin
                count_down <= dir_req;
            end
        end
    end
endmodule

// ===== presettable_up_down_counter4_tb_top.sv
// Purpose: self-checking bench for the up/down counter
// Assumes: zero-wait APB slave
// Notes: clock, enable and direction pins come from pudc_ctl_model
`timescale 1ns/1ps
module presettable_up_down_counter4_tb_top;
    import pudc_pkg::*;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [PUDC_ADDR_W-1:0] paddr = 12'h0;
    logic [PUDC_DATA_W-1:0] pwdata = 32'h0;
    logic [PUDC_DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic count_clock;
    logic count_enable_n;
    logic count_down;
    logic preset_load_n = 1'h1;
    logic [PUDC_CNT_W-1:0] preset_data_in = 4'h0;
    logic [PUDC_CNT_W-1:0] count_value_out;
    logic terminal_count_flag;
    logic ripple_clock_out;
    logic run = 1'h0;
    logic en_req = 1'h0;
    logic dir_req = 1'h0;
    logic [PUDC_CNT_W-1:0] cnt_rip;
    logic [PUDC_CNT_W-1:0] cnt_syn;
    logic en_syn_n;
    logic [PUDC_DATA_W-1:0] rd;
    logic err;
    int n_errors = 0;
    int checks = 0;

    always #25 pclk = !pclk;

    pudc_counter i_pudc_counter (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .count_clock, .count_enable_n, .count_down,
        .preset_load_n, .preset_data_in, .count_value_out, .terminal_count_flag,
        .ripple_clock_out);
    pudc_ctl_model i_pudc_ctl_model (.pclk, .presetn, .run, .en_req, .dir_req,
        .count_clock, .count_enable_n, .count_down);

    // ripple-clocked upper stage
    pudc_counter i_pudc_counter_rip (.pclk, .presetn, .psel(1'h0), .penable(1'h0),
        .pwrite(1'h0), .paddr(12'h0), .pwdata(32'h0), .prdata(), .pready(), .pslverr(),
        .count_clock(ripple_clock_out), .count_enable_n, .count_down,
        .preset_load_n(1'h1), .preset_data_in(4'h0), .count_value_out(cnt_rip),
        .terminal_count_flag(), .ripple_clock_out());

    // synchronous upper stage: lower flag gated with the global enable
    assign en_syn_n = count_enable_n | ~terminal_count_flag;
    pudc_counter i_pudc_counter_syn (.pclk, .presetn, .psel(1'h0), .penable(1'h0),
        .pwrite(1'h0), .paddr(12'h0), .pwdata(32'h0), .prdata(), .pready(), .pslverr(),
        .count_clock, .count_enable_n(en_syn_n), .count_down,
        .preset_load_n(1'h1), .preset_data_in(4'h0), .count_value_out(cnt_syn),
        .terminal_count_flag(), .ripple_clock_out());

    // ==========================================================
    // tasks
    task automatic end_of_test();
        if (n_errors == 0 && checks > 0)
        begin
            $display("Result: passed");
        end
        else
        begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        // only the watchdog ends a wait for ready
        while (pready !== 1'h1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    // n full count clock periods, then settle
    task automatic steps(input int n);
        run <= 1'h1;
        repeat (4 * n) @(posedge pclk);
        run <= 1'h0;
        repeat (3) @(posedge pclk);
    endtask

    task automatic pins(input logic en, input logic dir);
        en_req <= en;
        dir_req <= dir;
        repeat (3) @(posedge pclk);
    endtask

    // clock keeps running while load is held, to show it is ignored
    task automatic load(input logic [3:0] v);
        preset_data_in <= v;
        preset_load_n <= 1'h0;
        steps(1);
        chk(count_value_out, v);
        preset_load_n <= 1'h1;
        @(posedge pclk);
    endtask

    // ==========================================================
    // tests
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        repeat (3) @(posedge pclk);
        chk(count_value_out, PUDC_CNT_RST);
        chk(ripple_clock_out, 1'h1);
        pins(1'h1, 1'h0);
        load(4'hd);
        steps(1);
        chk(count_value_out, 4'he);
        steps(1);
        chk(terminal_count_flag, 1'h1);
        steps(1);
        chk(count_value_out, 4'h0);
        chk(terminal_count_flag, 1'h0);
        chk(cnt_rip, 4'h1);
        chk(cnt_syn, 4'h1);
        load(4'hf);
        pins(1'h0, 1'h0);
        steps(2);
        chk(count_value_out, 4'hf);
        chk(terminal_count_flag, 1'h1);
        pins(1'h0, 1'h1);
        chk(terminal_count_flag, 1'h0);
        pins(1'h1, 1'h1);
        steps(1);
        chk(count_value_out, 4'he);
        load(4'h1);
        steps(1);
        chk(terminal_count_flag, 1'h1);
        steps(1);
        chk(count_value_out, 4'hf);
        chk(cnt_rip, 4'h1);
        chk(cnt_syn, 4'h1);
        apb(1'h0, PUDC_OFS_WRAPS, 32'h0);
        chk(rd, 32'h2);
        apb(1'h1, PUDC_OFS_PRESET, 32'h5);
        apb(1'h1, PUDC_OFS_CTRL, 32'h2);
        apb(1'h0, PUDC_OFS_STATUS, 32'h0);
        chk(rd, 32'ha5);
        apb(1'h1, PUDC_OFS_CTRL, 32'h1);
        steps(1);
        chk(count_value_out, 4'h5);
        apb(1'h0, PUDC_OFS_CTRL, 32'h0);
        chk(rd, 32'h1);
        apb(1'h1, PUDC_OFS_CTRL, 32'h0);
        steps(1);
        chk(count_value_out, 4'h4);
        apb(1'h0, 12'h010, 32'h0);
        chk(err, 1'h1);
        chk(rd, 32'h0);
        end_of_test();
    end

    initial
    begin
        repeat (3000) @(posedge pclk);
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_of_test();
    end
endmodule
